/* File: poe_pse_pkg.sv */
/*
 * Shared constants and types for the single-port PoE sourcing controller:
 * timing in milliseconds, mode codes, class levels, limits, register map.
 * Assumes a 20 MHz system clock and a 1 ms prescaled tick.
 */
package poe_pse_pkg;
    // ------------------------------------------------------------
    // Clock and tick
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 20_000_000;
    localparam int TICK_HZ     = 1_000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;

    // ------------------------------------------------------------
    // Intervals in ms
    // ------------------------------------------------------------
    localparam logic [11:0] RETRY_MS     = 12'h07D0; // 2000
    localparam logic [11:0] DET_MS       = 12'h0064; // 100
    localparam logic [11:0] CLS_SHORT_MS = 12'h000C; // 12
    localparam logic [11:0] CLS_LONG_MS  = 12'h0058; // 88
    localparam logic [11:0] MARK_MS      = 12'h000A; // 10
    localparam logic [11:0] INRUSH_MS    = 12'h003C; // 60
    localparam logic [11:0] CUT_MS       = 12'h003C; // 60
    localparam logic [11:0] HOLD_MIN_MS  = 12'h0006; // 6
    localparam logic [11:0] HOLD_WIN_MS  = 12'h0145; // 325
    localparam logic [11:0] BLINK_MS     = 12'h00C8; // 200

    // ------------------------------------------------------------
    // Strap modes and class levels
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_LEG_T2 = 3'h0;
    localparam logic [2:0] MODE_T1     = 3'h1;
    localparam logic [2:0] MODE_T2     = 3'h2;
    localparam logic [2:0] MODE_LEG_HP = 3'h3;
    localparam logic [2:0] MODE_BT1P   = 3'h4;
    localparam logic [2:0] MODE_BT3    = 3'h5;
    localparam logic [2:0] CLASS_4     = 3'h4;
    localparam logic [2:0] CLASS_5     = 3'h5;
    localparam logic [2:0] CLASS_OVER  = 3'h6;

    // Power ceilings in watts
    localparam logic [6:0] CEIL_20W = 7'h14;
    localparam logic [6:0] CEIL_38W = 7'h26;
    localparam logic [6:0] CEIL_46W = 7'h2E;
    localparam logic [6:0] CEIL_75W = 7'h4B;

    // Overload limit select: 350, 660, 815, 1320 mA
    localparam logic [1:0] ILIM_350  = 2'h0;
    localparam logic [1:0] ILIM_660  = 2'h1;
    localparam logic [1:0] ILIM_815  = 2'h2;
    localparam logic [1:0] ILIM_1320 = 2'h3;

    // Fault codes equal the number of status pulses
    localparam logic [2:0] FLT_NONE  = 3'h0;
    localparam logic [2:0] FLT_SHORT = 3'h1;
    localparam logic [2:0] FLT_OVER  = 3'h2;
    localparam logic [2:0] FLT_SIG   = 3'h3;
    localparam logic [2:0] FLT_UV    = 3'h4;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CTRL_EN  = 0;
    localparam int CTRL_CLR = 1;
    localparam logic CTRL_EN_RST = 1'b1;

    typedef enum logic [3:0] {
        S_LOCK, S_IDLE, S_DET, S_CLS, S_MARK, S_INRUSH, S_ON, S_RETRY
    } pse_state_t;
endpackage : poe_pse_pkg

/* File: poe_pse_port_controller.sv */
/*
 * Sequencer for one PoE sourcing port: supply lockout, strap mode,
 * signature detection with retry, at/bt classification, inrush,
 * hold-current monitoring, overload and short cutoff, status blink code,
 * and a classic Wishbone slave for control and state readback.
 * Assumes comparator and strap inputs from analog front-end circuits.
 */
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module poe_pse_port_controller #(
    parameter int TICK_CYCLES = poe_pse_pkg::TICK_CYCLES,
    parameter int PRE_W       = 16
) (
    input  wire logic        clk_sys_in,          // System clock
    input  wire logic        reset_n_in,          // Async reset, active low
    input  wire logic [2:0]  option_code_in,      // Decoded strap resistor
    input  wire logic        supply_below_t1_in,  // Supply under low-mode trip
    input  wire logic        supply_below_std_in, // Supply under normal trip
    input  wire logic        supply_above_t1_in,  // Supply over low-mode restart
    input  wire logic        supply_above_std_in, // Supply over normal restart
    input  wire logic        sig_valid_in,        // Signature in window
    input  wire logic [2:0]  class_level_in,      // Class current band
    input  wire logic        hold_cur_in,         // Current above hold level
    input  wire logic        overload_in,         // Current above overload limit
    input  wire logic        short_in,            // Current above short limit
    input  wire logic        wb_cyc_in,           // Wishbone cycle
    input  wire logic        wb_stb_in,           // Wishbone strobe
    input  wire logic        wb_we_in,            // Wishbone write
    input  wire logic [7:0]  wb_adr_in,           // Wishbone byte address
    input  wire logic [3:0]  wb_sel_in,           // Wishbone byte selects
    input  wire logic [31:0] wb_dat_in,           // Wishbone write data
    output logic [31:0]      wb_dat_out,          // Wishbone read data
    output logic             wb_ack_out,          // Wishbone acknowledge
    output logic             det_en_out,          // Signature probe on
    output logic             class_en_out,        // Class pulse voltage on
    output logic             port_power_out,      // Main port switch
    output logic [1:0]       ilim_sel_out,        // Overload limit select
    output logic [6:0]       power_ceil_out,      // Power ceiling in watts
    output logic             status_out           // Status pin
);
    typedef struct packed {
        logic [10:0]            sy1;
        logic [10:0]            sy2;
        logic [2:0]             mode;
        logic                   mode_ok;
        poe_pse_pkg::pse_state_t st;
        logic [11:0]            tmr;
        logic [PRE_W-1:0]       pre;
        logic                   tick;
        logic [1:0]             pulse;
        logic [2:0]             cls_a;
        logic                   grant;
        logic [1:0]             ilim;
        logic [6:0]             ceil;
        logic [3:0]             slot;
        logic [11:0]            btmr;
        logic [2:0]             last_fault;
        logic [11:0]            hold_run;
        logic [11:0]            hold_win;
        logic                   hold_seen;
        logic [11:0]            cut;
        logic                   enable;
        logic                   ack;
        logic [31:0]            dat;
        logic                   power;
        logic                   det;
        logic                   cls;
        logic                   status;
    } state_t;

    localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(TICK_CYCLES - 1);

    state_t r;
    state_t next_r;

    logic       s_sig;
    logic       s_hold;
    logic       s_over;
    logic       s_short;
    logic       s_low;
    logic       s_ok;
    logic [2:0] s_cls;
    logic       at_style;
    logic       bt_ext;

    // ------------------------------------------------------------
    // Synchronised comparators
    // ------------------------------------------------------------
    assign s_sig   = r.sy2[0];
    assign s_hold  = r.sy2[1];
    assign s_over  = r.sy2[2];
    assign s_short = r.sy2[3];
    assign s_cls   = r.sy2[10:8];
    assign s_low   = (r.mode == poe_pse_pkg::MODE_T1) ? r.sy2[4] : r.sy2[5];
    assign s_ok    = (r.mode == poe_pse_pkg::MODE_T1) ? r.sy2[6] : r.sy2[7];
    assign at_style = (r.mode == poe_pse_pkg::MODE_LEG_T2) ||
                      (r.mode == poe_pse_pkg::MODE_LEG_HP);
    assign bt_ext   = (r.mode == poe_pse_pkg::MODE_BT1P) ||
                      (r.mode == poe_pse_pkg::MODE_BT3);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic       go_fault;
        logic [2:0] fcode;
        logic       cls_done;
        logic       cls_err;
        logic       more;
        logic [11:0] width;
        go_fault = 1'b0;
        fcode    = poe_pse_pkg::FLT_NONE;
        cls_done = 1'b0;
        cls_err  = 1'b0;
        more     = 1'b0;
        width    = poe_pse_pkg::CLS_SHORT_MS;
        next_r   = r;

        next_r.sy1 = {class_level_in, supply_above_std_in, supply_above_t1_in,
                      supply_below_std_in, supply_below_t1_in,
                      short_in, overload_in, hold_cur_in, sig_valid_in};
        next_r.sy2 = r.sy1;

        // Strap is caught once after reset release
        if (!r.mode_ok)
        begin
            next_r.mode_ok = 1'b1;
            next_r.mode    = (option_code_in > poe_pse_pkg::MODE_BT3) ?
                             poe_pse_pkg::MODE_LEG_T2 : option_code_in;
        end

        case (r.mode)
            poe_pse_pkg::MODE_T1:     next_r.ceil = poe_pse_pkg::CEIL_20W;
            poe_pse_pkg::MODE_LEG_HP: next_r.ceil = poe_pse_pkg::CEIL_75W;
            poe_pse_pkg::MODE_BT1P:   next_r.ceil = poe_pse_pkg::CEIL_46W;
            poe_pse_pkg::MODE_BT3:    next_r.ceil = poe_pse_pkg::CEIL_75W;
            default:                  next_r.ceil = poe_pse_pkg::CEIL_38W;
        endcase

        // 1 ms tick shared by every timer
        next_r.tick = 1'b0;
        next_r.pre  = r.pre + 1'b1;
        if (r.pre == PRE_MAX)
        begin
            next_r.pre  = '0;
            next_r.tick = 1'b1;
        end
        if (r.tick)
        begin
            next_r.tmr = r.tmr + 1'b1;
        end

        case (r.st)
            poe_pse_pkg::S_LOCK:
            begin
                if (r.mode_ok && s_ok)
                begin
                    next_r.st  = poe_pse_pkg::S_IDLE;
                    next_r.tmr = '0;
                end
            end
            poe_pse_pkg::S_IDLE:
            begin
                if (r.enable)
                begin
                    next_r.st  = poe_pse_pkg::S_DET;
                    next_r.tmr = '0;
                end
            end
            poe_pse_pkg::S_DET:
            begin
                if (r.tmr == poe_pse_pkg::DET_MS)
                begin
                    next_r.tmr   = '0;
                    next_r.pulse = '0;
                    next_r.grant = 1'b0;
                    if (s_sig)
                    begin
                        next_r.st = poe_pse_pkg::S_CLS;
                    end
                    else
                    begin
                        next_r.st = poe_pse_pkg::S_RETRY;
                    end
                end
            end
            poe_pse_pkg::S_CLS:
            begin
                if (!at_style && r.pulse == 2'd0)
                begin
                    width = poe_pse_pkg::CLS_LONG_MS;
                end
                if (r.tmr == width)
                begin
                    next_r.tmr = '0;
                    if (s_cls >= poe_pse_pkg::CLASS_OVER)
                    begin
                        cls_err = 1'b1;
                    end
                    else
                    begin
                        case (r.pulse)
                            2'd0:
                            begin
                                next_r.cls_a = s_cls;
                                if (s_cls == poe_pse_pkg::CLASS_5 &&
                                    r.mode != poe_pse_pkg::MODE_LEG_HP)
                                begin
                                    cls_err = 1'b1;
                                end
                                more = !at_style ||
                                       (s_cls == poe_pse_pkg::CLASS_4);
                            end
                            2'd1:
                            begin
                                cls_err = (s_cls != r.cls_a);
                                more = bt_ext &&
                                       (r.cls_a == poe_pse_pkg::CLASS_4);
                            end
                            2'd2:
                            begin
                                more = (s_cls != r.cls_a);
                                next_r.grant = more;
                            end
                            default: more = 1'b0;
                        endcase
                    end
                    if (cls_err)
                    begin
                        go_fault = 1'b1;
                        fcode    = poe_pse_pkg::FLT_SIG;
                    end
                    else if (more)
                    begin
                        next_r.st    = poe_pse_pkg::S_MARK;
                        next_r.pulse = r.pulse + 1'b1;
                    end
                    else
                    begin
                        cls_done = 1'b1;
                    end
                end
            end
            poe_pse_pkg::S_MARK:
            begin
                if (r.tmr == poe_pse_pkg::MARK_MS)
                begin
                    next_r.st  = poe_pse_pkg::S_CLS;
                    next_r.tmr = '0;
                end
            end
            poe_pse_pkg::S_INRUSH:
            begin
                if (r.tmr == poe_pse_pkg::INRUSH_MS)
                begin
                    next_r.st       = poe_pse_pkg::S_ON;
                    next_r.hold_run = '0;
                    next_r.hold_win = '0;
                    next_r.hold_seen = 1'b0;
                end
            end
            poe_pse_pkg::S_ON:
            begin
                if (r.tick)
                begin
                    next_r.hold_run = s_hold ? r.hold_run + 1'b1 : '0;
                    next_r.hold_win = r.hold_win + 1'b1;
                    if (s_hold && r.hold_run + 1'b1 >= poe_pse_pkg::HOLD_MIN_MS)
                    begin
                        next_r.hold_seen = 1'b1;
                    end
                    if (r.hold_win + 1'b1 == poe_pse_pkg::HOLD_WIN_MS)
                    begin
                        next_r.hold_win  = '0;
                        next_r.hold_seen = 1'b0;
                        if (!r.hold_seen)
                        begin
                            next_r.st  = poe_pse_pkg::S_DET;
                            next_r.tmr = '0;
                        end
                    end
                end
            end
            poe_pse_pkg::S_RETRY:
            begin
                if (r.tmr == poe_pse_pkg::RETRY_MS)
                begin
                    next_r.st  = poe_pse_pkg::S_IDLE;
                    next_r.tmr = '0;
                end
            end
            default: next_r.st = poe_pse_pkg::S_LOCK;
        endcase

        // Overload limit from class and mode
        if (cls_done)
        begin
            next_r.st  = poe_pse_pkg::S_INRUSH;
            next_r.tmr = '0;
            next_r.cut = '0;
            if (r.mode == poe_pse_pkg::MODE_T1)
            begin
                next_r.ilim = poe_pse_pkg::ILIM_350;
            end
            else if (next_r.grant ||
                     (r.mode == poe_pse_pkg::MODE_LEG_HP &&
                      next_r.cls_a == poe_pse_pkg::CLASS_5))
            begin
                next_r.ilim = (r.mode == poe_pse_pkg::MODE_BT1P) ?
                              poe_pse_pkg::ILIM_815 : poe_pse_pkg::ILIM_1320;
            end
            else if (next_r.cls_a == poe_pse_pkg::CLASS_4)
            begin
                next_r.ilim = poe_pse_pkg::ILIM_660;
            end
            else
            begin
                next_r.ilim = poe_pse_pkg::ILIM_350;
            end
        end

        // Current protection while powered
        if (r.st == poe_pse_pkg::S_INRUSH || r.st == poe_pse_pkg::S_ON)
        begin
            if (!s_over)
            begin
                next_r.cut = '0;
            end
            else if (r.tick)
            begin
                next_r.cut = r.cut + 1'b1;
            end
            if (s_short)
            begin
                go_fault = 1'b1;
                fcode    = poe_pse_pkg::FLT_SHORT;
            end
            else if (s_over && r.cut >= poe_pse_pkg::CUT_MS)
            begin
                go_fault = 1'b1;
                fcode    = poe_pse_pkg::FLT_OVER;
            end
        end

        if (go_fault)
        begin
            next_r.st  = poe_pse_pkg::S_RETRY;
            next_r.tmr = '0;
        end

        // Supply lockout overrides everything once operating
        if (r.st != poe_pse_pkg::S_LOCK && s_low)
        begin
            next_r.st  = poe_pse_pkg::S_LOCK;
            go_fault   = 1'b1;
            fcode      = poe_pse_pkg::FLT_UV;
        end
        if (!r.enable && r.st != poe_pse_pkg::S_LOCK && !s_low)
        begin
            next_r.st = poe_pse_pkg::S_IDLE;
        end

        // ------------------------------------------------------------
        // Status blink code
        // ------------------------------------------------------------
        if (r.slot != 4'h0 && r.tick)
        begin
            next_r.btmr = r.btmr + 1'b1;
            if (r.btmr + 1'b1 == poe_pse_pkg::BLINK_MS)
            begin
                next_r.btmr = '0;
                next_r.slot = r.slot - 1'b1;
            end
        end
        if (go_fault)
        begin
            next_r.slot = {fcode, 1'b0};
            next_r.btmr = '0;
        end

        // Outputs registered from the next state
        next_r.det    = (next_r.st == poe_pse_pkg::S_DET);
        next_r.cls    = (next_r.st == poe_pse_pkg::S_CLS);
        next_r.power  = (next_r.st == poe_pse_pkg::S_INRUSH) ||
                        (next_r.st == poe_pse_pkg::S_ON);
        next_r.status = (next_r.slot != 4'h0) ? next_r.slot[0] :
                        (next_r.st == poe_pse_pkg::S_ON);

        // ------------------------------------------------------------
        // Wishbone slave
        // ------------------------------------------------------------
        next_r.ack = wb_cyc_in && wb_stb_in && !r.ack;
        if (wb_cyc_in && wb_stb_in && !r.ack)
        begin
            case (wb_adr_in)
                poe_pse_pkg::REG_CTRL:
                    next_r.dat = {31'h0000_0000, r.enable};
                poe_pse_pkg::REG_STATUS:
                    next_r.dat = {7'h00, r.ceil, r.ilim, r.mode, r.last_fault,
                                  r.grant, r.cls_a, r.status, r.power, r.st};
                default:
                    next_r.dat = 32'h0000_0000;
            endcase
        end
        if (wb_cyc_in && wb_stb_in && wb_we_in && r.ack && wb_sel_in[0] &&
            wb_adr_in == poe_pse_pkg::REG_CTRL)
        begin
            next_r.enable = wb_dat_in[poe_pse_pkg::CTRL_EN];
            if (wb_dat_in[poe_pse_pkg::CTRL_CLR])
            begin
                next_r.last_fault = poe_pse_pkg::FLT_NONE;
            end
        end
        if (go_fault)
        begin
            next_r.last_fault = fcode;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r        <= '0;
            r.st     <= poe_pse_pkg::S_LOCK;
            r.enable <= poe_pse_pkg::CTRL_EN_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign wb_dat_out     = r.dat;
    assign wb_ack_out     = r.ack;
    assign det_en_out     = r.det;
    assign class_en_out   = r.cls;
    assign port_power_out = r.power;
    assign ilim_sel_out   = r.ilim;
    assign power_ceil_out = r.ceil;
    assign status_out     = r.status;
endmodule : poe_pse_port_controller

`default_nettype wire

/* File: pd_model.sv */
/* Powered device stand-in: valid signature, steady class 4, hold current.
   Assumes the controller's probe, class and power outputs. */
`timescale 1ns/1ps
`default_nettype none
module pd_model (
    input  wire logic det_en_in,   // Probe on
    input  wire logic cls_in,      // Class pulse on
    input  wire logic pw_in,       // Port powered
    output logic      sig_out,     // Signature seen
    output logic [2:0] lvl_out,    // Class band
    output logic      hold_out     // Hold current
);
    assign sig_out  = det_en_in;
    assign lvl_out  = cls_in ? 3'h4 : 3'h3;
    assign hold_out = pw_in;
endmodule : pd_model
`default_nettype wire

/* File: poe_pse_assertions.sv */
/* Checker of the port controller outputs.
   Assumes binding to poe_pse_port_controller. */
`timescale 1ns/1ps
`default_nettype none
module poe_pse_chk (
    input wire logic       clk_sys_in,         // Clock
    input wire logic       reset_n_in,         // Reset
    input wire logic       supply_below_t1_in, // Low supply
    input wire logic       short_in,           // Short
    input wire logic       wb_cyc_in,          // Cycle
    input wire logic       wb_stb_in,          // Strobe
    input wire logic       wb_ack_out,         // Ack
    input wire logic       det_en_out,         // Probe
    input wire logic       class_en_out,       // Class
    input wire logic       port_power_out,     // Power
    input wire logic [6:0] power_ceil_out      // Ceiling
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    sequence low_supply;
        supply_below_t1_in [*5];
    endsequence
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held");
    a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("no ack");
    a_short_cut: assert property (short_in && port_power_out |-> ##[1:5] !port_power_out)
        else $error("short kept");
    a_sig_first: assert property (!(port_power_out && det_en_out))
        else $error("power in probe");
    a_class_unpowered: assert property (class_en_out |-> !port_power_out)
        else $error("power in class");
    a_probe_class: assert property (!(det_en_out && class_en_out))
        else $error("probe and class");
    a_ceil_legal: assert property ($past(reset_n_in, 3) |-> power_ceil_out inside {7'h14, 7'h26, 7'h2E, 7'h4B})
        else $error("bad ceiling");
    a_supply_off: assert property (low_supply |-> !port_power_out)
        else $error("power in lockout");
endmodule : poe_pse_chk
bind poe_pse_port_controller poe_pse_chk u_chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .supply_below_t1_in(supply_below_t1_in), .short_in(short_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .det_en_out(det_en_out),
    .class_en_out(class_en_out), .port_power_out(port_power_out), .power_ceil_out(power_ceil_out));
`default_nettype wire

/* File: tb_top.sv */
/* Bench: per strap mode powers a device; modes 0 to 2 then inject a fault, modes 3 to 5 disable the port.
   Assumes controller, checker bind and device model. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 0, rst_n, ovl, sh, lo, cyc, stb, we, ack, det, cls, pw, st, sig, hold;
    logic [2:0]  code, lvl;
    logic [1:0]  ilim;
    logic [6:0]  ceil;
    logic [7:0]  adr;
    logic [31:0] dat, q, rd;
    int          miscompares = 0, n_checks = 0, cycles = 0;
    int          ceil_tab[6] = '{38, 20, 38, 75, 46, 75};
    int          flt_q[$] = '{2, 1, 4};
    poe_pse_port_controller #(.TICK_CYCLES(20)) dut (.clk_sys_in(clk), .reset_n_in(rst_n),
        .option_code_in(code), .supply_below_t1_in(lo), .supply_below_std_in(lo),
        .supply_above_t1_in(!lo), .supply_above_std_in(!lo), .sig_valid_in(sig), .class_level_in(lvl),
        .hold_cur_in(hold), .overload_in(ovl), .short_in(sh), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(rd),
        .wb_ack_out(ack), .det_en_out(det), .class_en_out(cls), .port_power_out(pw),
        .ilim_sel_out(ilim), .power_ceil_out(ceil), .status_out(st));
    pd_model pd (.det_en_in(det), .cls_in(cls), .pw_in(pw), .sig_out(sig), .lvl_out(lvl), .hold_out(hold));
    always #25 clk = ~clk;
    task automatic print_verdict;
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic wait_lvl(input bit p, input logic v);
        for (int n = 0; n < 9000 && (p ? pw : st) !== v; n++)
            @(posedge clk);
    endtask : wait_lvl
    initial
    begin
        void'($urandom(63));
        {ovl, sh, lo, cyc, stb, we, adr, dat} <= '0;
        for (int m = 0; m < 6; m++)
        begin
            rst_n <= 1'b0;
            code <= m[2:0];
            repeat (20) @(posedge clk);
            rst_n <= 1'b1;
            wait_lvl(0, 1'b1);
            chk({st, pw}, 2'b11);
            chk(ceil, ceil_tab[m]);
            chk(ilim, m == 1 ? 0 : 1);
            wb(0, 8'h04, 0);
            chk({q[15:13], q[3:0]}, {m[2:0], 4'h6});
            ovl <= 1'b1;
            repeat ($urandom_range(1000, 20)) @(posedge clk);
            ovl <= 1'b0;
            @(posedge clk);
            chk(pw, 1);
            if (m < 3)
            begin
                {lo, sh, ovl} <= 3'b1 << m;
                wait_lvl(1, 1'b0);
                repeat (100) @(posedge clk);
                chk(st, 0);
                wb(0, 8'h04, 0);
                chk(q[12:10], flt_q.pop_front());
                repeat (4000) @(posedge clk);
                chk(st, 1);
                {lo, sh, ovl} <= 3'b0;
            end
            else
            begin
                wb(1, 8'h00, 0);
                wait_lvl(1, 1'b0);
                chk(pw, 0);
                wb(0, 8'($urandom_range(63, 2) * 4), $urandom());
                chk(q, 0);
            end
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
